// File: fst_map.svh
`ifndef FST_MAP_SVH
`define FST_MAP_SVH
// ==========================================
// Register offsets
`define FST_OFF_CTRL     8'h00
`define FST_OFF_CMD      8'h04
`define FST_OFF_EXPOSURE 8'h08
`define FST_OFF_RATE     8'h0c
`define FST_OFF_MINPER   8'h10
`define FST_OFF_STATUS   8'h14
// ==========================================
// Control fields
`define FST_STD_BIT      0
`define FST_TRIGON_BIT   1
`define FST_SRCLINE_BIT  2
`define FST_FALL_BIT     3
`define FST_CONT_BIT     4
`define FST_RLIM_BIT     5
`define FST_WIDTH_BIT    6
`define FST_ASTEN_BIT    7
`define FST_CTRL_W       8
// Legacy control, line source, single frame
`define FST_CTRL_RST     8'h04
// ==========================================
// Command fields (write-one pulses)
`define FST_CMD_START    0
`define FST_CMD_STOP     1
`define FST_CMD_SWTRIG   2
`define FST_CMD_ASTRIG   3
// ==========================================
// Timing resets, in pclk cycles
`define FST_EXP_RST      32'h0000_0096
`define FST_RATE_RST     32'h000f_4240
`define FST_MINPER_RST   32'h0000_03e8
`endif

// File: fst_pkg.sv
`default_nettype none
package fst_pkg;
    // Gray codes along idle, arm, wait, expose, recover
    typedef enum logic [2:0] {
        st_idle    = 3'h0,
        st_arm     = 3'h1,
        st_wait    = 3'h3,
        st_expose  = 3'h2,
        st_recover = 3'h6
    } state_type;
endpackage : fst_pkg
`default_nettype wire

// File: frame_start_trigger_control.sv
// Contract
// - One frame per accepted trigger while waiting
// - Waiting only after mode, start, start-trigger
// - Triggers outside waiting status are ignored
// - Trigger mode setting: off or on
// - Mode off: all triggers made internally
// - Single frame: one trigger per start
// - Continuous: triggers until stop command
// - Limit off: run at maximum rate
// - Limit below maximum: use programmed period
// - Limit above maximum: clamp to maximum
// - Mode off: exposure from programmed time
// - Mode on: trigger from selected source
// - Edge polarity picks rising or falling
// - Line one is source after reset
// - Software source: programmed exposure time
// - Line source: timed or trigger-width exposure
// - Active only in standard mode, legacy default
// - Leave waiting at exposure, return when ready
// - Rising-edge timed exposure starts at edge
//
// The APB interface to the registers and the register offsets were left to the implementer.
`include "fst_map.svh"
`default_nettype none
module frame_start_trigger_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        line1_in,
    output var  logic        frame_start,
    output var  logic        exposure_active,
    output var  logic        waiting_frame
);
    // ==========================================
    // APB slave
    logic [`FST_CTRL_W-1:0] ctrl_q;
    logic [31:0]            exp_q;
    logic [31:0]            rate_q;
    logic [31:0]            minper_q;
    logic [31:0]            prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;
    fst_pkg::state_type     state_q;
    fst_pkg::state_type     state_d;
    logic [31:0]            gap_q;
    logic [31:0]            expcnt_q;
    logic                   stop_pend_q;
    logic                   frame_q;
    logic                   expo_q;
    logic                   wait_q;

    wire sel_ctrl   = paddr == `FST_OFF_CTRL;
    wire sel_cmd    = paddr == `FST_OFF_CMD;
    wire sel_exp    = paddr == `FST_OFF_EXPOSURE;
    wire sel_rate   = paddr == `FST_OFF_RATE;
    wire sel_minper = paddr == `FST_OFF_MINPER;
    wire sel_status = paddr == `FST_OFF_STATUS;
    wire mapped     = sel_ctrl | sel_cmd | sel_exp | sel_rate | sel_minper | sel_status;
    wire setup      = psel & ~penable;
    // Writes land only at the completing access edge
    wire wr_en      = psel & penable & pwrite & pready_q & mapped;
    wire [31:0] status_word = {24'h0, frame_q, expo_q, wait_q, stop_pend_q,
                               1'b0, state_q};
    wire [31:0] rdata_d =
        sel_ctrl   ? {24'h0, ctrl_q} :
        sel_exp    ? exp_q :
        sel_rate   ? rate_q :
        sel_minper ? minper_q :
        sel_status ? status_word : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q  <= (setup & ~pwrite) ? rdata_d : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= `FST_CTRL_RST;
            exp_q    <= `FST_EXP_RST;
            rate_q   <= `FST_RATE_RST;
            minper_q <= `FST_MINPER_RST;
        end else if (wr_en) begin
            if (sel_ctrl)   ctrl_q   <= pwdata[`FST_CTRL_W-1:0];
            if (sel_exp)    exp_q    <= pwdata;
            if (sel_rate)   rate_q   <= pwdata;
            if (sel_minper) minper_q <= pwdata;
        end
    end

    // ==========================================
    // Control fields and commands
    wire std_on    = ctrl_q[`FST_STD_BIT];
    wire trig_on   = ctrl_q[`FST_TRIGON_BIT];
    wire src_line  = ctrl_q[`FST_SRCLINE_BIT];
    wire fall_edge = ctrl_q[`FST_FALL_BIT];
    wire cont_mode = ctrl_q[`FST_CONT_BIT];
    wire rlim_on   = ctrl_q[`FST_RLIM_BIT];
    wire width_sel = ctrl_q[`FST_WIDTH_BIT];
    wire ast_en    = ctrl_q[`FST_ASTEN_BIT];
    wire cmd_wr    = wr_en & sel_cmd;
    wire cmd_start = cmd_wr & pwdata[`FST_CMD_START];
    wire cmd_stop  = cmd_wr & pwdata[`FST_CMD_STOP];
    wire cmd_sw    = cmd_wr & pwdata[`FST_CMD_SWTRIG];
    wire cmd_ast   = cmd_wr & pwdata[`FST_CMD_ASTRIG];

    // ==========================================
    // Line one synchroniser and edge pulse
    logic line_s1_q;
    logic line_s2_q;
    logic line_s3_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_s1_q <= 1'b0;
            line_s2_q <= 1'b0;
            line_s3_q <= 1'b0;
        end else begin
            line_s1_q <= line1_in;
            line_s2_q <= line_s1_q;
            line_s3_q <= line_s2_q;
        end
    end
    // Only the second and third stages feed logic
    wire line_rise   = line_s2_q & ~line_s3_q;
    wire line_fall   = ~line_s2_q & line_s3_q;
    wire line_edge   = fall_edge ? line_fall : line_rise;
    wire line_active = fall_edge ? ~line_s2_q : line_s2_q;

    // ==========================================
    // Trigger sources and qualification
    // Limit can only slow the rate, never beat the ready period
    wire rate_slower = rate_q > minper_q;
    wire [31:0] eff_period = (rlim_on & rate_slower) ? rate_q : minper_q;
    wire int_trig  = ~trig_on & (gap_q >= eff_period);
    wire ext_trig  = trig_on & (src_line ? line_edge : cmd_sw);
    wire any_trig  = int_trig | ext_trig;
    wire in_wait   = state_q == fst_pkg::st_wait;
    // A stop in the same cycle wins, so no pulse without a frame
    wire accept    = in_wait & any_trig & std_on & ~cmd_stop;
    // Trigger-width exposure only with a line source
    wire width_use = trig_on & src_line & width_sel;
    wire exp_done  = width_use ? ~line_active : (expcnt_q >= exp_q);
    // Ready one cycle early so internal starts land MINPER apart
    wire ready_nxt = ({1'b0, gap_q} + 33'h1) >= {1'b0, minper_q};
    wire stopping  = stop_pend_q | cmd_stop;

    // ==========================================
    // Acquisition status machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            fst_pkg::st_idle: begin
                if (cmd_start) begin
                    state_d = ast_en ? fst_pkg::st_arm : fst_pkg::st_wait;
                end
            end
            fst_pkg::st_arm: begin
                if (cmd_stop) begin
                    state_d = fst_pkg::st_idle;
                end else if (cmd_ast) begin
                    state_d = fst_pkg::st_wait;
                end
            end
            fst_pkg::st_wait: begin
                if (cmd_stop) begin
                    state_d = fst_pkg::st_idle;
                end else if (accept) begin
                    state_d = fst_pkg::st_expose;
                end
            end
            fst_pkg::st_expose: begin
                if (exp_done) begin
                    state_d = fst_pkg::st_recover;
                end
            end
            fst_pkg::st_recover: begin
                if (ready_nxt) begin
                    // Single frame: one trigger per start
                    state_d = (stopping | ~cont_mode) ? fst_pkg::st_idle
                                                      : fst_pkg::st_wait;
                end
            end
            default: begin
                state_d = fst_pkg::st_idle;
            end
        endcase
        if (!std_on) begin
            state_d = fst_pkg::st_idle;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= fst_pkg::st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================
    // Frame spacing and exposure counters
    // Gap saturates so a long idle never wraps into a false wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 32'hffff_ffff;
        end else if (accept) begin
            gap_q <= 32'h1;
        end else if (gap_q != 32'hffff_ffff) begin
            gap_q <= gap_q + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expcnt_q <= 32'h0;
        end else if (accept) begin
            expcnt_q <= 32'h1;
        end else if (state_q == fst_pkg::st_expose && expcnt_q != 32'hffff_ffff) begin
            expcnt_q <= expcnt_q + 32'h1;
        end
    end

    // Stop during a frame lets the frame finish first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_pend_q <= 1'b0;
        end else if (cmd_stop) begin
            stop_pend_q <= 1'b1;
        end else if (cmd_start) begin
            stop_pend_q <= 1'b0;
        end
    end

    // ==========================================
    // Registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_q <= 1'b0;
            expo_q  <= 1'b0;
            wait_q  <= 1'b0;
        end else begin
            frame_q <= accept;
            expo_q  <= state_d == fst_pkg::st_expose;
            wait_q  <= state_d == fst_pkg::st_wait;
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign frame_start     = frame_q;
    assign exposure_active = expo_q;
    assign waiting_frame   = wait_q;

    // ==========================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_accept;
        in_wait && any_trig && std_on && !cmd_stop;
    endsequence
    sequence s_frame;
        frame_start && exposure_active && !waiting_frame;
    endsequence

    a_accept_frame: assert property (s_accept |=> s_frame)
        else $error("accepted trigger did not start a frame");
    a_ignore_nowait: assert property (any_trig && !in_wait |=> !frame_start)
        else $error("trigger outside waiting status started a frame");
    a_wait_entry: assert property ($rose(waiting_frame) |->
                  $past(state_q) == fst_pkg::st_idle && !$past(ast_en) ||
                  $past(state_q) == fst_pkg::st_arm ||
                  $past(state_q) == fst_pkg::st_recover)
        else $error("waiting entered without start conditions");
    a_int_spacing: assert property (accept && !trig_on |->
                   gap_q >= minper_q && (!rlim_on || gap_q >= rate_q))
        else $error("internal trigger spacing violated");
    a_line_edge: assert property (accept && trig_on && src_line |->
                 (fall_edge ? line_fall : line_rise))
        else $error("line trigger accepted without selected edge");
    a_no_ext_off: assert property (in_wait && std_on && trig_on && !ext_trig |=> !frame_start)
        else $error("frame started without external trigger");
    a_timed_len: assert property (state_q == fst_pkg::st_expose && !width_use &&
                 expcnt_q < exp_q |=> state_q == fst_pkg::st_expose)
        else $error("timed exposure ended early");
    a_width_end: assert property (state_q == fst_pkg::st_expose && width_use &&
                 !line_active |=> state_q == fst_pkg::st_recover)
        else $error("trigger-width exposure did not end");
    a_legacy_idle: assert property (!std_on |=> state_q == fst_pkg::st_idle)
        else $error("block active in legacy control");
    a_stop_wait: assert property (in_wait && cmd_stop |=> state_q == fst_pkg::st_idle ##1
                 !frame_start)
        else $error("stop did not end frame generation");
    a_single_end: assert property (state_q == fst_pkg::st_recover && ready_nxt && !cont_mode
                  |=> state_q == fst_pkg::st_idle)
        else $error("single frame mode kept acquiring");
    a_sync_pulse: assert property (line_edge |=> !line_edge)
        else $error("line edge pulse longer than one cycle");
    a_max_rate: assert property (state_q == fst_pkg::st_recover && ready_nxt && cont_mode &&
                !stopping && std_on |=> in_wait)
        else $error("maximum rate not reached");
    a_stop_frame: assert property (stop_pend_q && state_q == fst_pkg::st_recover &&
                  ready_nxt |=> state_q == fst_pkg::st_idle)
        else $error("pending stop did not end acquisition");
    a_frame_pulse: assert property (frame_start |=> !frame_start)
        else $error("frame start longer than one cycle");
    a_exp_level: assert property (exposure_active == (state_q == fst_pkg::st_expose))
        else $error("exposure flag out of step with status");
    a_wait_level: assert property (waiting_frame == in_wait)
        else $error("waiting flag out of step with status");

    // ==========================================
    // Bus assertions
    sequence s_setup;
        psel && !penable;
    endsequence

    a_apb_ready: assert property (s_setup |=> pready)
        else $error("no ready in access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held past access cycle");
    a_map_error: assert property (s_setup |=> pslverr == !$past(mapped))
        else $error("error response does not match address map");
    a_read_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access cycle");
    a_write_lands: assert property (wr_en && sel_exp |=> exp_q == $past(pwdata))
        else $error("exposure write did not land");
endmodule : frame_start_trigger_control
`default_nettype wire

// File: trigger_line_source.sv
`default_nettype none
// ==========================================
// Outside party driving input line one
module trigger_line_source (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       fire,
    input  wire logic [7:0] hold_cycles,
    output var  logic       line1_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_q;
    // Rests low between requests, one high pulse per requested frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q   <= 8'h00;
            line1_in <= 1'b0;
        end else if (fire) begin
            left_q   <= hold_cycles;
            line1_in <= 1'b1;
        end else if (left_q > 8'h01) begin
            left_q <= left_q - 8'h01;
        end else begin
            left_q   <= 8'h00;
            line1_in <= 1'b0;
        end
    end
endmodule : trigger_line_source
`default_nettype wire

// File: frame_start_trigger_control_test.sv
`default_nettype none
module frame_start_trigger_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        line1_in, frame_start, exposure_active, waiting_frame, er, fire;
    logic [7:0]  hold_cycles;
    int          bad_count, cmp_count, cyc, fs_cnt, fs_at, fs_gap, exp_run, exp_len, b;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_type;
    row_type rows[7] = '{'{8'h00, 32'h0000_0004, 1'b0}, '{8'h04, 32'h0, 1'b0},
        '{8'h08, 32'h0000_0096, 1'b0}, '{8'h0c, 32'h000f_4240, 1'b0},
        '{8'h10, 32'h0000_03e8, 1'b0}, '{8'h14, 32'h0, 1'b0}, '{8'h18, 32'h0, 1'b1}};
    frame_start_trigger_control i_frame_start_trigger_control (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .line1_in(line1_in),
        .frame_start(frame_start), .exposure_active(exposure_active),
        .waiting_frame(waiting_frame));
    trigger_line_source i_trigger_line_source (.pclk(pclk), .presetn(presetn), .fire(fire),
        .hold_cycles(hold_cycles), .line1_in(line1_in));
    // ==========================================
    // Clock, monitor, watchdog
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (frame_start === 1'b1) begin
            fs_cnt <= fs_cnt + 1;
            fs_gap <= cyc - fs_at;
            fs_at  <= cyc;
        end
        if (exposure_active === 1'b1) exp_run <= exp_run + 1;
        else if (exp_run != 0) begin
            exp_len <= exp_run;
            exp_run <= 0;
        end
    end
    // Whole run needs about 720 cycles
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        tally_and_finish();
    end
    // ==========================================
    // Tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Held until pready is sampled high; no wait count assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        forever begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic pulse(input logic [7:0] n);
        fire        <= 1'b1;
        hold_cycles <= n;
        @(posedge pclk);
        fire <= 1'b0;
    endtask : pulse
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // ==========================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, fire} = '0;
        {paddr, pwdata, hold_cycles} = '0;
        {bad_count, cmp_count, cyc, fs_cnt, fs_at, fs_gap, exp_run, exp_len} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk("rdata", rd, rows[i].d);
            chk("slverr", {31'h0, er}, {31'h0, rows[i].e});
        end
        // Legacy mode after reset ignores start
        b = fs_cnt;
        apb(1'b1, 8'h04, 32'h1);
        repeat (30) @(posedge pclk);
        chk("legacy", fs_cnt - b, 0);
        apb(1'b1, 8'h10, 32'h14);
        apb(1'b1, 8'h08, 32'h4);
        apb(1'b1, 8'h00, 32'h01);
        b = fs_cnt;
        apb(1'b1, 8'h04, 32'h1);
        repeat (100) @(posedge pclk);
        chk("single", fs_cnt - b, 1);
        chk("exp_timed", exp_len, 4);
        apb(1'b1, 8'h00, 32'h11);
        apb(1'b1, 8'h04, 32'h1);
        repeat (60) @(posedge pclk);
        chk("gap_max", fs_gap, 20);
        apb(1'b1, 8'h0c, 32'h28);
        apb(1'b1, 8'h00, 32'h31);
        repeat (100) @(posedge pclk);
        chk("gap_lim", fs_gap, 40);
        apb(1'b1, 8'h0c, 32'ha);
        repeat (60) @(posedge pclk);
        chk("gap_clamp", fs_gap, 20);
        apb(1'b1, 8'h04, 32'h2);
        repeat (30) @(posedge pclk);
        b = fs_cnt;
        repeat (60) @(posedge pclk);
        chk("stopped", fs_cnt - b, 0);
        // Software source behind an acquisition start trigger
        apb(1'b1, 8'h00, 32'h93);
        apb(1'b1, 8'h04, 32'h1);
        repeat (5) @(posedge pclk);
        chk("arm", {31'h0, waiting_frame}, 32'h0);
        apb(1'b1, 8'h04, 32'h8);
        repeat (3) @(posedge pclk);
        chk("wait", {31'h0, waiting_frame}, 32'h1);
        b = fs_cnt;
        apb(1'b1, 8'h04, 32'h4);
        apb(1'b1, 8'h04, 32'h4);
        repeat (30) @(posedge pclk);
        chk("sw_trig", fs_cnt - b, 1);
        chk("exp_sw", exp_len, 4);
        // Line one, rising then falling edge
        apb(1'b1, 8'h00, 32'h17);
        repeat (30) @(posedge pclk);
        b = fs_cnt;
        pulse(8'h05);
        repeat (30) @(posedge pclk);
        chk("rise", fs_cnt - b, 1);
        apb(1'b1, 8'h00, 32'h1f);
        b = fs_cnt;
        pulse(8'h14);
        repeat (10) @(posedge pclk);
        chk("fall_early", fs_cnt - b, 0);
        repeat (30) @(posedge pclk);
        chk("fall", fs_cnt - b, 1);
        // Exposure shaped by the line pulse
        apb(1'b1, 8'h00, 32'h57);
        pulse(8'h0c);
        repeat (40) @(posedge pclk);
        chk("exp_width", {31'h0, exp_len > 4 && exp_len <= 14}, 32'h1);
        // Mid-run reset returns to legacy control with line one
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl_reset", rd, 32'h0000_0004);
        chk("wait_reset", {31'h0, waiting_frame}, 32'h0);
        apb(1'b1, 8'h04, 32'h2);
        tally_and_finish();
    end
endmodule : frame_start_trigger_control_test
`default_nettype wire
